// ==== hdl/frlc_top.sv ====
// fire release logic controller: control transfer, release logic, panel
`timescale 1ns/1ps
`default_nettype none
module frlc_top
  import frlc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned STEP_CYCLES = TEST_STEP_CYCLES,
  parameter int unsigned BLINK_HALF = BLINK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] node_addr,
  input wire logic configured,
  input wire logic low_power,
  input wire logic [7:0] chan_fault,
  input wire logic comm_lost,
  input wire logic [1:0] op_mode,
  input wire logic cross_zoned,
  input wire logic manual_delayed,
  input wire logic [2:0] delay_sel,
  input wire logic [1:0] abort_mode,
  input wire logic [5:0] release_on_s,
  input wire logic [1:0] bell_pat_single,
  input wire logic [1:0] bell_pat_one_zone,
  input wire logic [1:0] bell_pat_two_zone,
  input wire logic abort_in,
  input wire logic manual_in,
  input wire logic superv_in,
  input wire logic det_a_in,
  input wire logic det_b_in,
  input wire logic ctrl_bell,
  input wire logic ctrl_rel7,
  input wire logic ctrl_rel8,
  input wire logic ctrl_reset,
  output logic bell_out,
  output logic [1:0] bell_pattern,
  output logic rel7_out,
  output logic rel8_out,
  output logic det_power,
  output logic local_control,
  output logic manual_reset_req,
  output logic [7:0] input_status,
  output logic led_power,
  output logic led_dev_fault,
  output logic [7:0] led_red,
  output logic [7:0] led_amber,
  output logic powerup_done
);
  logic rst_meta;
  logic rst_n;
  logic [31:0] pre_cnt;
  logic tick_1s;
  frlc_rel_e rel_state;
  logic [5:0] delay_cnt;
  logic [5:0] on_cnt;
  logic [1:0] det_cnt;
  logic from_manual;
  logic second_alarm;
  logic abort_armed;
  logic abort_q;
  logic any_alarm;
  logic two_zone;
  logic local_on;
  logic reset_ok;
  logic [5:0] start_delay;
  logic loc_bell;
  logic loc_rel;
  logic [7:0] chan_active;

  // ==========================================================
  // reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // one-second prescaler
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= '0;
      tick_1s <= 1'b0;
    end else if (pre_cnt == TICK_DIV - 1) begin
      pre_cnt <= '0;
      tick_1s <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 32'h1;
      tick_1s <= 1'b0;
    end
  end

  // ==========================================================
  // control transfer and reset acceptance
  // supervisory input is deliberately absent from all release terms
  assign any_alarm = manual_in | det_a_in | det_b_in;
  assign two_zone = det_a_in & det_b_in;
  assign reset_ok = ctrl_reset & ~manual_in;
  // a release begun under local control stays local until it is done
  assign local_on = (op_mode == MODE_LOCAL_ONLY)
    | ((op_mode == MODE_BACKUP) & comm_lost)
    | ((op_mode == MODE_BACKUP) & local_control
       & (rel_state == REL_DELAY || rel_state == REL_FIRE));
  // manual delay clipped to the manual maximum
  assign start_delay = (from_manual && !manual_delayed) ? 6'h00
    : (from_manual && frlc_delay_s(delay_sel) > 6'(MANUAL_MAX_S)) ? 6'(MANUAL_MAX_S)
    : frlc_delay_s(delay_sel);

  // ==========================================================
  // local release sequence; idle in controller-only mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_state <= REL_IDLE;
      delay_cnt <= 6'h00;
      on_cnt <= 6'h00;
      from_manual <= 1'b0;
      second_alarm <= 1'b0;
      abort_armed <= 1'b0;
      abort_q <= 1'b0;
    end else if (op_mode == MODE_CTRL_ONLY) begin
      rel_state <= REL_IDLE;
      abort_q <= abort_in;
    end else if (reset_ok && rel_state != REL_DELAY && rel_state != REL_FIRE) begin
      rel_state <= REL_IDLE;
      delay_cnt <= 6'h00;
      on_cnt <= 6'h00;
      from_manual <= 1'b0;
      second_alarm <= 1'b0;
      abort_armed <= 1'b0;
      abort_q <= abort_in;
    end else begin
      abort_q <= abort_in;
      case (rel_state)
        REL_IDLE: begin
          from_manual <= manual_in;
          abort_armed <= abort_in;
          if (manual_in || (!cross_zoned && any_alarm) || (cross_zoned && two_zone)) begin
            second_alarm <= cross_zoned;
            rel_state <= REL_DELAY;
            delay_cnt <= manual_in ? ((!manual_delayed) ? 6'h00
              : (frlc_delay_s(delay_sel) > 6'(MANUAL_MAX_S)) ? 6'(MANUAL_MAX_S)
              : frlc_delay_s(delay_sel)) : frlc_delay_s(delay_sel);
          end else if (cross_zoned && (det_a_in || det_b_in)) begin
            rel_state <= REL_ZONE1;
          end
        end
        REL_ZONE1: begin
          if (abort_in) abort_armed <= 1'b1;
          if (two_zone || manual_in) begin
            second_alarm <= 1'b1;
            from_manual <= manual_in;
            rel_state <= REL_DELAY;
            delay_cnt <= (manual_in && !manual_delayed) ? 6'h00
              : (manual_in && frlc_delay_s(delay_sel) > 6'(MANUAL_MAX_S)) ? 6'(MANUAL_MAX_S)
              : frlc_delay_s(delay_sel);
          end
        end
        REL_DELAY: begin
          // abort acts on detector alarms only
          if (!from_manual && abort_in && abort_mode == ABORT_MODE2) begin
            if (!abort_q) delay_cnt <= start_delay;
          end else if (delay_cnt == 6'h00) begin
            rel_state <= REL_FIRE;
            on_cnt <= release_on_s;
          end else if (tick_1s) begin
            // modes 1 and pre-second-alarm hold at the abort floor
            if (!from_manual && abort_in && delay_cnt <= 6'(ABORT_HOLD_S)
                && (abort_mode == ABORT_MODE1
                    || (abort_mode == ABORT_PRE_SECOND
                        && (abort_armed || !second_alarm)))) begin
              delay_cnt <= delay_cnt;
            end else begin
              delay_cnt <= delay_cnt - 6'h01;
            end
          end
        end
        REL_FIRE: begin
          if (on_cnt == 6'h00) begin
            rel_state <= REL_DONE;
          end else if (tick_1s) begin
            on_cnt <= on_cnt - 6'h01;
          end
        end
        REL_DONE: rel_state <= REL_DONE;
        default: rel_state <= REL_IDLE;
      endcase
    end
  end

  // ==========================================================
  // detector power cut after an accepted reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_cnt <= 2'h0;
      det_power <= 1'b1;
    end else if (reset_ok && (rel_state == REL_DONE || rel_state == REL_IDLE
                              || rel_state == REL_ZONE1)) begin
      det_cnt <= 2'(DET_RESET_S);
      det_power <= 1'b0;
    end else if (det_cnt != 2'h0) begin
      det_power <= 1'b0;
      if (tick_1s) det_cnt <= det_cnt - 2'h1;
    end else begin
      det_power <= 1'b1;
    end
  end

  // ==========================================================
  // output steering between controller and local logic
  assign loc_bell = (rel_state != REL_IDLE) && (rel_state != REL_DONE);
  assign loc_rel = (rel_state == REL_FIRE);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bell_out <= 1'b0;
      bell_pattern <= 2'h0;
      rel7_out <= 1'b0;
      rel8_out <= 1'b0;
      local_control <= 1'b0;
      manual_reset_req <= 1'b0;
      input_status <= 8'h00;
    end else begin
      local_control <= local_on;
      manual_reset_req <= (rel_state == REL_DONE);
      input_status <= {3'h0, det_b_in, det_a_in, superv_in, manual_in, abort_in};
      if (local_on) begin
        // controller output commands are refused here
        bell_out <= loc_bell;
        rel7_out <= loc_rel;
        rel8_out <= loc_rel;
        if (!cross_zoned) begin
          bell_pattern <= bell_pat_single;
        end else if (rel_state == REL_ZONE1) begin
          bell_pattern <= bell_pat_one_zone;
        end else begin
          bell_pattern <= bell_pat_two_zone;
        end
      end else begin
        bell_out <= ctrl_bell;
        rel7_out <= ctrl_rel7;
        rel8_out <= ctrl_rel8;
        bell_pattern <= bell_pat_single;
      end
    end
  end

  assign chan_active = {rel8_out, rel7_out, bell_out, det_b_in, det_a_in, superv_in,
    manual_in, abort_in};

  // ==========================================================
  // front panel indicators
  frlc_panel #(
    .STEP_CYCLES(STEP_CYCLES),
    .BLINK_HALF(BLINK_HALF)
  ) u_frlc_panel (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_1s(tick_1s),
    .node_addr(node_addr),
    .configured(configured),
    .low_power(low_power),
    .chan_active(chan_active),
    .chan_fault(chan_fault),
    .led_power(led_power),
    .led_dev_fault(led_dev_fault),
    .led_red(led_red),
    .led_amber(led_amber),
    .powerup_done(powerup_done)
  );
endmodule
`default_nettype wire

// ==== hdl/frlc_pkg.sv ====
// constants and types shared by the fire release logic controller
// ==========================================================
// How it works
// - power-up lights power and fault indicators before channel test
// - red lit 1 to 8, cleared 1 to 8, then same for amber
// - address switches shown on red for two seconds, then fault off
// - unconfigured after power-up: all amber flash together
// - red follows channel activity, amber blinks low power/unconfigured, steady fault
// - controller-only mode: remote drives outputs, local logic idle
// - backup mode: local logic takes outputs when communication is lost
// - communication back: control returns unless a local release is running
// - finished release reports manual reset; reset clears timers and latches
// - reset ignored while manual release input is in alarm
// - local-only: local logic, status reported, output commands refused, reset accepted
// - manual release undelayed or delayed with delay clipped to 30 s
// - release outputs 7 and 8 held off by 0 to 60 s delay
// - bell on channel 6 starts at once on any release input
// - abort mode 1: timer counts down and holds at 10 s
// - abort mode 2: timer reloads on abort, resumes after release
// - pre-second-alarm abort: as mode 1 only if before second alarm
// - bell pattern: one in single zone, one-zone/two-zone in cross-zoned
// - supervisory channel 3 is status only, no release effect
// - single zone: alarm on 2, 4 or 5 gives bell, delay, release
// - abort holds or reloads the delay timer of detector alarms only, per abort mode
// - cross-zoned: first zone bell only, second zone two-zone bell and release
// - release outputs energised for configured on-time then dropped
// - accepted reset cuts detector power on 4 and 5 for two seconds
package frlc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned ADDR_SHOW_S = 2;
  localparam int unsigned DET_RESET_S = 2;
  localparam int unsigned MANUAL_MAX_S = 30;
  localparam int unsigned ABORT_HOLD_S = 10;
  localparam int unsigned DELAY_STEP_S = 10;
  localparam logic [2:0] DELAY_SEL_MAX = 3'h6;
  localparam int unsigned TEST_STEP_CYCLES = 5000000;
  localparam int unsigned BLINK_CYCLES = 12500000;
  localparam logic [1:0] MODE_CTRL_ONLY = 2'h0;
  localparam logic [1:0] MODE_BACKUP = 2'h1;
  localparam logic [1:0] MODE_LOCAL_ONLY = 2'h2;
  localparam logic [1:0] ABORT_MODE1 = 2'h0;
  localparam logic [1:0] ABORT_MODE2 = 2'h1;
  localparam logic [1:0] ABORT_PRE_SECOND = 2'h2;
  typedef enum logic [2:0] {REL_IDLE, REL_ZONE1, REL_DELAY, REL_FIRE, REL_DONE} frlc_rel_e;
  typedef enum logic [2:0] {PU_LAMPS, PU_RED_ON, PU_RED_OFF, PU_AMB_ON, PU_AMB_OFF,
    PU_ADDR, PU_RUN} frlc_pu_e;

  // delay selection in seconds, clipped to the table range
  function automatic logic [5:0] frlc_delay_s(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > DELAY_SEL_MAX) ? DELAY_SEL_MAX : sel;
    return 6'(s * DELAY_STEP_S);
  endfunction
endpackage

// ==== hdl/frlc_panel.sv ====
// front-panel indicator sequencer: power-up test, address display, run display
`timescale 1ns/1ps
`default_nettype none
module frlc_panel
  import frlc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = TEST_STEP_CYCLES,
  parameter int unsigned BLINK_HALF = BLINK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tick_1s,
  input wire logic [7:0] node_addr,
  input wire logic configured,
  input wire logic low_power,
  input wire logic [7:0] chan_active,
  input wire logic [7:0] chan_fault,
  output logic led_power,
  output logic led_dev_fault,
  output logic [7:0] led_red,
  output logic [7:0] led_amber,
  output logic powerup_done
);
  frlc_pu_e state;
  logic [31:0] step_cnt;
  logic [31:0] blink_cnt;
  logic blink;
  logic [2:0] idx;
  logic [1:0] sec_cnt;
  logic step;

  assign step = (step_cnt == STEP_CYCLES - 1);

  // ==========================================================
  // step and blink timers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= '0;
    end else if (step) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 32'h1;
    end
  end

  // common blink for all amber so channels flash in step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end else if (blink_cnt == BLINK_HALF - 1) begin
      blink_cnt <= '0;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // ==========================================================
  // power-up sequence
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PU_LAMPS;
      idx <= 3'h0;
      sec_cnt <= 2'h0;
    end else begin
      case (state)
        PU_LAMPS: if (step) state <= PU_RED_ON;
        PU_RED_ON, PU_RED_OFF, PU_AMB_ON, PU_AMB_OFF: begin
          if (step) begin
            idx <= idx + 3'h1;
            if (idx == 3'h7) begin
              case (state)
                PU_RED_ON: state <= PU_RED_OFF;
                PU_RED_OFF: state <= PU_AMB_ON;
                PU_AMB_ON: state <= PU_AMB_OFF;
                default: begin
                  state <= PU_ADDR;
                  sec_cnt <= 2'h0;
                end
              endcase
            end
          end
        end
        PU_ADDR: begin
          if (tick_1s) begin
            sec_cnt <= sec_cnt + 2'h1;
            if (sec_cnt == 2'(ADDR_SHOW_S - 1)) state <= PU_RUN;
          end
        end
        PU_RUN: state <= PU_RUN;
        default: state <= PU_LAMPS;
      endcase
    end
  end

  // ==========================================================
  // indicator drive, all registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_power <= 1'b0;
      led_dev_fault <= 1'b0;
      led_red <= 8'h00;
      led_amber <= 8'h00;
      powerup_done <= 1'b0;
    end else begin
      led_power <= 1'b1;
      led_dev_fault <= (state != PU_RUN);
      powerup_done <= (state == PU_RUN);
      case (state)
        PU_LAMPS: begin
          led_red <= 8'h00;
          led_amber <= 8'h00;
        end
        PU_RED_ON: led_red <= led_red | (8'h01 << idx);
        PU_RED_OFF: led_red <= led_red & ~(8'h01 << idx);
        PU_AMB_ON: led_amber <= led_amber | (8'h01 << idx);
        PU_AMB_OFF: led_amber <= led_amber & ~(8'h01 << idx);
        PU_ADDR: begin
          led_red <= node_addr;
          led_amber <= 8'h00;
        end
        default: begin
          led_red <= chan_active;
          if (!configured || low_power) begin
            led_amber <= {8{blink}};
          end else begin
            led_amber <= chan_fault;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== sim/frlc_top_sva.sv ====
// assertion checker bound to the fire release logic controller top
`timescale 1ns/1ps
`default_nettype none
module frlc_top_sva
  import frlc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] op_mode,
  input wire logic comm_lost,
  input wire logic manual_in,
  input wire logic [5:0] release_on_s,
  input wire logic bell_out,
  input wire logic rel7_out,
  input wire logic det_power,
  input wire logic local_control,
  input wire logic manual_reset_req,
  input wire logic led_power,
  input wire logic led_dev_fault,
  input wire logic [7:0] led_red,
  input wire logic powerup_done
);
  int rel_cnt;
  int cut_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // =====
  // length of a local release pulse and of a detector power cut
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rel_cnt <= 0;
      cut_cnt <= 0;
    end else begin
      rel_cnt <= (rel7_out && local_control) ? rel_cnt + 1 : 0;
      cut_cnt <= det_power ? 0 : cut_cnt + 1;
    end
  end
  // =====
  // control transfer
  property p_ctrl_only;
    (op_mode == MODE_CTRL_ONLY) [*6] |-> !local_control;
  endproperty
  a_ctrl_only: assert property (p_ctrl_only)
    else $error("local control in controller-only mode");
  property p_backup_lost;
    (op_mode == MODE_BACKUP && comm_lost) [*6] |-> local_control;
  endproperty
  a_backup_lost: assert property (p_backup_lost)
    else $error("no local control after communication loss");
  property p_local_only;
    (op_mode == MODE_LOCAL_ONLY) [*6] |-> local_control;
  endproperty
  a_local_only: assert property (p_local_only)
    else $error("no local control in local-only mode");
  property p_hold_release;
    op_mode == MODE_BACKUP && $past(local_control) && local_control && $rose(rel7_out)
      && release_on_s != 6'h00 |=> local_control;
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("control handed back during release");
  // =====
  // release logic
  property p_bell_now;
    local_control && !manual_reset_req && !bell_out && $rose(manual_in) |-> ##[1:3] bell_out;
  endproperty
  a_bell_now: assert property (p_bell_now)
    else $error("bell late after manual alarm");
  property p_reset_blocked;
    manual_in [*3] ##0 manual_reset_req |=> manual_reset_req;
  endproperty
  a_reset_blocked: assert property (p_reset_blocked)
    else $error("reset taken with manual alarm");
  property p_rel_on_time;
    rel_cnt <= (int'(release_on_s) + 2) * TICK_DIV;
  endproperty
  a_rel_on_time: assert property (p_rel_on_time)
    else $error("release output too long");
  property p_det_cut;
    cut_cnt <= (DET_RESET_S + 1) * TICK_DIV + 4;
  endproperty
  a_det_cut: assert property (p_det_cut)
    else $error("detector power cut too long");
  // =====
  // power-up panel
  property p_lamp_first;
    $rose(led_red[0]) && !powerup_done |-> led_power && led_dev_fault;
  endproperty
  a_lamp_first: assert property (p_lamp_first)
    else $error("channel test without power-up lamps");
  property p_fault_off;
    $rose(powerup_done) |-> !led_dev_fault && led_power;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("device fault lamp on after power-up");
endmodule
bind frlc_top frlc_top_sva #(.TICK_DIV(TICK_DIV)) u_frlc_top_sva (.core_clk, .reset_n,
  .op_mode, .comm_lost, .manual_in, .release_on_s, .bell_out, .rel7_out, .det_power,
  .local_control, .manual_reset_req, .led_power, .led_dev_fault, .led_red, .powerup_done);
`default_nettype wire

// ==== sim/frlc_ctrl_model.sv ====
// behavioural model of the remote system controller
`timescale 1ns/1ps
`default_nettype none
module frlc_ctrl_model (
  input wire logic online,
  input wire logic cmd_out,
  input wire logic cmd_reset,
  output logic comm_lost,
  output logic ctrl_bell,
  output logic ctrl_rel7,
  output logic ctrl_rel8,
  output logic ctrl_reset
);
  // an offline controller sends nothing
  assign comm_lost = !online;
  assign ctrl_bell = online && cmd_out;
  assign ctrl_rel7 = online && cmd_out;
  assign ctrl_rel8 = online && cmd_out;
  assign ctrl_reset = online && cmd_reset;
endmodule
`default_nettype wire

// ==== sim/frlc_tb_top.sv ====
// self-checking bench for the fire release logic controller
`timescale 1ns/1ps
`default_nettype none
module frlc_tb_top;
  import frlc_pkg::*;
  localparam int T = 10;
  logic core_clk = 0, reset_n = 0, configured = 0, low_power = 0, cross_zoned = 0;
  logic manual_delayed = 0, abort_in = 0, manual_in = 0, superv_in = 0;
  logic det_a_in = 0, det_b_in = 0, online = 1, cmd_out = 0, cmd_reset = 0;
  logic [7:0] node_addr = 8'hA5, chan_fault = 8'h00, last_r = 8'h00, last_a = 8'h00;
  logic [1:0] op_mode = MODE_BACKUP, abort_mode = ABORT_MODE1;
  logic [1:0] bell_pat_single = 2'h1, bell_pat_one_zone = 2'h2, bell_pat_two_zone = 2'h3;
  logic [2:0] delay_sel = 3'h0;
  logic [5:0] release_on_s = 6'h02;
  logic [7:0] red_q[$], amb_q[$];
  wire logic bell_out, rel7_out, rel8_out, det_power, local_control, manual_reset_req;
  wire logic led_power, led_dev_fault, powerup_done;
  wire logic comm_lost, ctrl_bell, ctrl_rel7, ctrl_rel8, ctrl_reset;
  wire logic [1:0] bell_pattern;
  wire logic [7:0] input_status, led_red, led_amber;
  int mismatches = 0, cmp_count = 0, n, on, off, bad, addr_n;

  // clock
  always #10 core_clk = ~core_clk;

  frlc_ctrl_model u_frlc_ctrl_model (.online, .cmd_out, .cmd_reset, .comm_lost, .ctrl_bell,
    .ctrl_rel7, .ctrl_rel8, .ctrl_reset);
  frlc_top #(.TICK_DIV(T), .STEP_CYCLES(4), .BLINK_HALF(4)) u_frlc_top (.core_clk, .reset_n,
    .node_addr, .configured, .low_power, .chan_fault, .comm_lost, .op_mode, .cross_zoned,
    .manual_delayed, .delay_sel, .abort_mode, .release_on_s, .bell_pat_single,
    .bell_pat_one_zone, .bell_pat_two_zone, .abort_in, .manual_in, .superv_in, .det_a_in,
    .det_b_in, .ctrl_bell, .ctrl_rel7, .ctrl_rel8, .ctrl_reset, .bell_out, .bell_pattern,
    .rel7_out, .rel8_out, .det_power, .local_control, .manual_reset_req, .input_status,
    .led_power, .led_dev_fault, .led_red, .led_amber, .powerup_done);

  // =====
  // checking and closing
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge core_clk);
  endtask
  function automatic logic probe(int s);
    case (s)
      0: return rel7_out;
      1: return !rel7_out;
      2: return powerup_done;
      3: return bell_out;
      4: return det_power;
      5: return local_control;
      default: return !local_control;
    endcase
  endfunction
  // bounded wait, a spent bound ends the run
  task automatic wait_on(int s, int lim, output int k);
    for (k = 0; probe(s) !== 1'b1; k++) begin
      @(negedge core_clk);
      if (k > lim) begin
        chk("wait bound", 0, 1);
        conclude();
      end
    end
  endtask
  // model: release delay in seconds
  function automatic int exp_fire(int src, int dsel, int ab_off);
    int d;
    d = ((dsel > 6) ? 6 : dsel) * 10;
    if (src == 2) return manual_delayed ? ((d > 30) ? 30 : d) : 0;
    if (ab_off < 0) return d;
    if (abort_mode == ABORT_MODE2) return ab_off + d;
    return (ab_off + 10 > d) ? ab_off + 10 : d;
  endfunction
  task automatic send_reset();
    cmd_reset = 1;
    cyc(3);
    cmd_reset = 0;
    cyc(2);
  endtask

  // =====
  // one alarm from src (0 zone a, 1 zone b, 2 manual) to accepted reset
  task automatic fire_seq(int src, int dsel, int ab_on, int ab_off);
    int fin;
    int k;
    fin = exp_fire(src, dsel, ab_off) * T;
    delay_sel = 3'(dsel);
    cmd_out = 1;
    abort_in = (ab_on < 0 && ab_off >= 0);
    cyc(2);
    det_a_in = (src == 0);
    det_b_in = (src == 1);
    manual_in = (src == 2);
    wait_on(3, 4, k);
    chk("bell pattern", bell_pattern, cross_zoned ? bell_pat_one_zone : bell_pat_single);
    if (fin > 0) chk("refused command", rel7_out, 0);
    cyc(2);
    chk("status", input_status, {3'h0, det_b_in, det_a_in, superv_in, manual_in, abort_in});
    if (cross_zoned) begin
      cyc(fin + 2 * T);
      chk("one zone only", rel7_out, 0);
      det_b_in = 1;
      cyc(4);
      chk("two zone bell", bell_pattern, bell_pat_two_zone);
    end
    for (k = 0; rel7_out !== 1'b1; k++) begin
      @(negedge core_clk);
      if (k > fin + 3 * T) begin
        chk("fire wait", 0, 1);
        conclude();
      end
      if (k == ab_on * T) abort_in = 1;
      if (k == ab_off * T) abort_in = 0;
    end
    chk("fire time", (k + T + 8 >= fin) && (k <= fin + 2 * T), 1);
    chk("second output", rel8_out, 1);
    wait_on(1, (release_on_s + 2) * T, k);
    chk("on time", (k + T >= release_on_s * T) && (k <= release_on_s * T + T + 4), 1);
    cyc(3);
    chk("reset request", manual_reset_req, 1);
    det_a_in = 0;
    det_b_in = 0;
    abort_in = 0;
    cmd_out = 0;
    send_reset();
    chk("reset refused", manual_reset_req, manual_in);
    manual_in = 0;
    send_reset();
    chk("reset taken", {manual_reset_req, det_power}, 0);
    wait_on(4, 3 * T + 4, k);
    chk("power cut", k + T + 8 >= 2 * T, 1);
  endtask

  // =====
  // stimulus
  initial begin
    n = $urandom(32'hDA5D);
    cyc(5);
    reset_n = 1;
    for (n = 0; powerup_done !== 1'b1; n++) begin
      @(negedge core_clk);
      if (n > 3000) begin
        chk("powerup wait", 0, 1);
        conclude();
      end
      if (n == 3) chk("power-up lamps", {led_power, led_dev_fault}, 2'h3);
      if (led_red !== last_r) red_q.push_back(led_red);
      if (led_amber !== last_a) amb_q.push_back(led_amber);
      if (led_red === node_addr) addr_n++;
      last_r = led_red;
      last_a = led_amber;
    end
    for (int i = 0; i < 16; i++) begin
      chk("red step", red_q[i], (i < 8) ? 8'hFF >> (7 - i) : 8'(8'hFF << (i - 7)));
      chk("amber step", amb_q[i], (i < 8) ? 8'hFF >> (7 - i) : 8'(8'hFF << (i - 7)));
    end
    chk("address", red_q[16], node_addr);
    chk("address time", addr_n >= T && addr_n <= 2 * T + 4, 1);
    chk("lamps after power-up", {led_power, led_dev_fault}, 2'h2);
    repeat (16) begin
      @(negedge core_clk);
      on |= (led_amber === 8'hFF);
      off |= (led_amber === 8'h00);
      bad |= (led_amber !== 8'hFF && led_amber !== 8'h00);
    end
    chk("amber blink", bad * 4 + on * 2 + off, 3);
    configured = 1;
    superv_in = 1;
    chan_fault = 8'h10;
    cyc(6);
    chk("red input", led_red[2], 1);
    chk("amber steady", led_amber[4], 1);
    cyc(5);
    chk("amber steady", led_amber[4], 1);
    chan_fault = 8'h00;
    op_mode = MODE_LOCAL_ONLY;
    for (int i = 0; i < 8; i++) begin
      manual_delayed = 1'($urandom % 2);
      release_on_s = 6'(1 + $urandom % 3);
      superv_in = 1'($urandom % 2);
      fire_seq(i % 3, i, -1, -1);
    end
    manual_delayed = 1;
    fire_seq(0, 3, 5, 25);
    abort_mode = ABORT_MODE2;
    fire_seq(1, 3, 5, 8);
    fire_seq(2, 2, 3, 6);
    abort_mode = ABORT_PRE_SECOND;
    fire_seq(0, 3, -1, 25);
    cross_zoned = 1;
    fire_seq(0, 1, -1, -1);
    cross_zoned = 0;
    op_mode = MODE_CTRL_ONLY;
    online = 0;
    det_a_in = 1;
    cyc(3 * T);
    chk("local idle", {local_control, rel7_out, bell_out}, 0);
    online = 1;
    cmd_out = 1;
    cyc(4);
    chk("controller drive", rel7_out, 1);
    cmd_out = 0;
    det_a_in = 0;
    op_mode = MODE_BACKUP;
    cyc(4);
    chk("backup online", local_control, 0);
    online = 0;
    delay_sel = 3'h1;
    release_on_s = 6'h03;
    wait_on(5, 4, n);
    det_a_in = 1;
    wait_on(0, 12 * T, n);
    online = 1;
    cyc(3);
    chk("held in release", local_control, 1);
    wait_on(6, (release_on_s + 3) * T, n);
    chk("handed back", rel7_out, 0);
    det_a_in = 0;
    send_reset();
    conclude();
  end
endmodule
`default_nettype wire
